// >>> design/battery_backup_power_domain.sv
// control logic of the battery-backed power domain: supply switch, detectors, crystal gating, registers
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "battery_backup_map.svh"
module battery_backup_power_domain #(
  parameter int KHZ_DIVIDE = `KHZ_DIVIDE,
  parameter int HZ_DIVIDE  = `HZ_DIVIDE
) (
  input  wire logic                            clk,
  input  wire logic                            reset,
  input  wire battery_backup_pkg::bus_req_t    busReq,
  output logic      [7:0]                      readData,
  input  wire logic                            mainPowerOnReset,
  input  wire logic                            mainBrownout,
  input  wire logic                            mainMonitorEnabled,
  input  wire logic                            vbatPresent,
  input  wire logic                            vbatLow,
  input  wire logic                            crystalIn,
  input  wire logic                            crystalStable,
  input  wire logic                            crystalFault,
  input  wire logic                            ulpTick,
  output battery_backup_pkg::power_ctl_t       powerCtl,
  output logic                                 crystalEnable,
  output logic                                 failMonitorEnable,
  output logic                                 crystalRawClock,
  output logic                                 counterTick
);

  battery_backup_pkg::domain_state_t s_q;
  battery_backup_pkg::domain_state_t s_d;

  logic [`PIN_COUNT-1:0] pinLevel;
  logic [`PIN_COUNT-1:0] pinRise;
  logic                  mainGood;
  logic                  switchToBattery;
  logic                  hostWrite;
  logic                  hostRead;
  logic                  ctrlWrite;
  logic                  domainReset;
  logic                  khzTick;
  logic                  hzTick;
  logic                  onBatteryNow;

  // every pin comes from outside the clock domain
  pin_sync #(
    .WIDTH (`PIN_COUNT)
  ) u_pin_sync (
    .clk   (clk),
    .reset (reset),
    .pinIn ({ulpTick, crystalFault, crystalStable, crystalIn, vbatLow,
             vbatPresent, mainMonitorEnabled, mainBrownout, mainPowerOnReset}),
    .level (pinLevel),
    .rise  (pinRise)
  );

  // write-one-to-clear with set winning over the clear
  function automatic logic sticky(input logic cur, input logic setEv, input logic clearEv);
    sticky = setEv | (cur & ~clearEv);
  endfunction

  // address match of a request, used by both read and write decode
  function automatic logic hit(input battery_backup_pkg::bus_req_t req, input logic [2:0] where);
    hit = (req.addr == where);
  endfunction

  // main power counts as good only with both main resets released
  assign mainGood        = ~pinLevel[`PIN_MAIN_POR] & ~pinLevel[`PIN_MAIN_BROWNOUT];
  // switching relies on the monitor being on; with it off the domain stays on main
  assign switchToBattery = pinLevel[`PIN_MAIN_BROWNOUT] & pinLevel[`PIN_MONITOR_ON];

  // writes are ignored while on battery or while main power is not good; reads are not gated
  assign hostWrite = busReq.wr & mainGood & (s_q.supply == battery_backup_pkg::SUPPLY_MAIN);
  assign hostRead  = busReq.rd;
  assign ctrlWrite = hostWrite & hit(busReq, `BBK_CTRL_ADDR) & s_q.accessEnable;

  // domain reset is refused when the same write sets either oscillator enable
  assign domainReset = ctrlWrite & busReq.wdata[`CTRL_RESET_BIT]
                       & ~busReq.wdata[`CTRL_OSCEN_BIT] & ~busReq.wdata[`CTRL_FAILDET_BIT];

  // crystal edges divided down; dividers stand still until the crystal is enabled
  assign khzTick = s_q.oscEnable & pinRise[`PIN_CRYSTAL]
                   & (s_q.khzCount == 5'(KHZ_DIVIDE - 1));
  assign hzTick  = s_q.oscEnable & pinRise[`PIN_CRYSTAL]
                   & (s_q.hzCount == 15'(HZ_DIVIDE - 1));

  always_comb begin
    s_d              = s_q;
    s_d.mainGoodPrev = mainGood;
    s_d.readData     = 8'h00;

    // supply switch
    case (s_q.supply)
      battery_backup_pkg::SUPPLY_MAIN: begin
        if (switchToBattery) begin
          s_d.supply = battery_backup_pkg::SUPPLY_BATTERY;
        end
      end
      battery_backup_pkg::SUPPLY_BATTERY: begin
        if (mainGood) begin
          s_d.supply = battery_backup_pkg::SUPPLY_MAIN;
        end
      end
      default: begin
        s_d.supply = battery_backup_pkg::SUPPLY_MAIN;
      end
    endcase

    // main-side access gate drops whenever main power is not good
    if (!mainGood) begin
      s_d.accessEnable = 1'b0;
    end else if (ctrlWrite || (hostWrite && hit(busReq, `BBK_CTRL_ADDR))) begin
      if (busReq.wdata[`CTRL_ACCESS_BIT]) begin
        s_d.accessEnable = 1'b1;
      end
    end

    // battery flags, always reachable through status
    s_d.missingFlag = sticky(s_q.missingFlag, mainGood & ~s_q.mainGoodPrev & ~pinLevel[`PIN_VBAT_PRESENT],
                             hostWrite & hit(busReq, `BBK_STATUS_ADDR)
                             & busReq.wdata[`STAT_MISSING_BIT]);
    s_d.powerOnFlag = sticky(s_q.powerOnFlag, pinRise[`PIN_VBAT_PRESENT],
                             hostWrite & hit(busReq, `BBK_STATUS_ADDR)
                             & busReq.wdata[`STAT_POWERON_BIT]);
    // sampled on the ulp tick only, and only while running from the battery
    s_d.brownoutFlag = sticky(s_q.brownoutFlag,
                              pinRise[`PIN_ULP_TICK] & pinLevel[`PIN_VBAT_LOW]
                              & (s_q.supply == battery_backup_pkg::SUPPLY_BATTERY),
                              hostWrite & hit(busReq, `BBK_STATUS_ADDR)
                              & busReq.wdata[`STAT_BROWNOUT_BIT]);

    // crystal status flags
    s_d.readyFlag = sticky(s_q.readyFlag, s_q.oscEnable & pinLevel[`PIN_CRYSTAL_STABLE] & ~s_q.readyFlag,
                           hostWrite & hit(busReq, `BBK_STATUS_ADDR) & s_q.accessEnable
                           & busReq.wdata[`STAT_READY_BIT]);
    s_d.failFlag  = s_q.failFlag | (s_q.failMonEnable & pinLevel[`PIN_CRYSTAL_FAULT]);

    // control bits: enables are set-only, cleared by the domain reset
    if (ctrlWrite) begin
      s_d.clockSelect = busReq.wdata[`CTRL_CLKSEL_BIT];
      if (busReq.wdata[`CTRL_OSCEN_BIT]) begin
        s_d.oscEnable = 1'b1;
      end
      if (busReq.wdata[`CTRL_FAILDET_BIT]) begin
        s_d.failMonEnable = 1'b1;
      end
    end

    // retained registers
    if (hostWrite && s_q.accessEnable) begin
      if (hit(busReq, `BBK_BACKUP0_ADDR)) begin
        s_d.backup0 = busReq.wdata;
      end else if (hit(busReq, `BBK_BACKUP1_ADDR)) begin
        s_d.backup1 = busReq.wdata;
      end
    end

    // crystal dividers
    if (s_q.oscEnable && pinRise[`PIN_CRYSTAL]) begin
      s_d.khzCount = khzTick ? 5'h00 : s_q.khzCount + 5'h01;
      s_d.hzCount  = hzTick ? 15'h0000 : s_q.hzCount + 15'h0001;
    end
    // counter sees only the selected crystal output, never before enable
    s_d.counterTick = s_q.oscEnable & (s_q.clockSelect ? khzTick : hzTick);

    // domain reset returns the domain settings to their defaults
    if (domainReset) begin
      s_d.oscEnable     = 1'b0;
      s_d.failMonEnable = 1'b0;
      s_d.clockSelect   = 1'b0;
      s_d.readyFlag     = 1'b0;
      s_d.failFlag      = 1'b0;
      s_d.khzCount      = 5'h00;
      s_d.hzCount       = 15'h0000;
      s_d.backup0       = `BACKUP_RESET_VALUE;
      s_d.backup1       = `BACKUP_RESET_VALUE;
    end

    // read decode; domain contents other than the battery flags read as zero until access is enabled
    if (hostRead) begin
      if (hit(busReq, `BBK_CTRL_ADDR)) begin
        s_d.readData = s_q.accessEnable
                       ? {3'h0, s_q.clockSelect, s_q.oscEnable, s_q.failMonEnable, 2'b10}
                       : 8'h00;
      end else if (hit(busReq, `BBK_STATUS_ADDR)) begin
        s_d.readData = {s_q.missingFlag, 3'h0,
                        s_q.accessEnable & s_q.readyFlag, s_q.accessEnable & s_q.failFlag,
                        s_q.brownoutFlag, s_q.powerOnFlag};
      end else if (hit(busReq, `BBK_BACKUP0_ADDR)) begin
        s_d.readData = s_q.accessEnable ? s_q.backup0 : 8'h00;
      end else if (hit(busReq, `BBK_BACKUP1_ADDR)) begin
        s_d.readData = s_q.accessEnable ? s_q.backup1 : 8'h00;
      end else begin
        s_d.readData = 8'h00;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs toward the power path and the counter
  assign readData                 = s_q.readData;
  // one driver for the whole struct; three flags follow the supply state
  assign onBatteryNow             = (s_q.supply == battery_backup_pkg::SUPPLY_BATTERY);
  assign powerCtl                 = '{onBattery: onBatteryNow, detectorEnable: onBatteryNow,
                                      inputIsolate: onBatteryNow, mainDomainReset: ~s_q.mainGoodPrev};
  assign crystalEnable            = s_q.oscEnable;
  assign failMonitorEnable        = s_q.failMonEnable;
  assign crystalRawClock          = s_q.oscEnable & pinLevel[`PIN_CRYSTAL];
  assign counterTick              = s_q.counterTick;

  // checks next to the logic they guard
  switch_battery_a: assert property (@(posedge clk) disable iff (reset)
    (s_q.supply == battery_backup_pkg::SUPPLY_MAIN) && switchToBattery |=> powerCtl.onBattery)
    else $error("domain did not move to battery after main brown-out");

  switch_back_a: assert property (@(posedge clk) disable iff (reset)
    $fell(powerCtl.onBattery) |-> $past(mainGood))
    else $error("domain left battery while main resets were held");

  power_on_flag_a: assert property (@(posedge clk) disable iff (reset)
    pinRise[`PIN_VBAT_PRESENT] |=> s_q.powerOnFlag)
    else $error("battery power-on flag not set on new battery power");

  brownout_sample_a: assert property (@(posedge clk) disable iff (reset)
    $rose(s_q.brownoutFlag) |-> $past(pinRise[`PIN_ULP_TICK]) && $past(powerCtl.detectorEnable))
    else $error("brown-out flag set off the ulp tick or from main power");

  brownout_set_a: assert property (@(posedge clk) disable iff (reset)
    pinRise[`PIN_ULP_TICK] && pinLevel[`PIN_VBAT_LOW] && powerCtl.onBattery |=> s_q.brownoutFlag)
    else $error("battery low not flagged on the tick");

  input_ignore_a: assert property (@(posedge clk) disable iff (reset)
    powerCtl.onBattery && busReq.wr |=> $stable(s_q.backup0) && $stable(s_q.oscEnable))
    else $error("write altered the domain while on battery");

  access_block_a: assert property (@(posedge clk) disable iff (reset)
    !s_q.accessEnable && busReq.rd && hit(busReq, `BBK_BACKUP0_ADDR) |=> readData == 8'h00)
    else $error("backup register readable without access enable");

  no_tick_off_a: assert property (@(posedge clk) disable iff (reset)
    !s_q.oscEnable ##1 !s_q.oscEnable |-> !counterTick)
    else $error("counter tick before crystal enable");

  missing_flag_a: assert property (@(posedge clk) disable iff (reset)
    mainGood && !s_q.mainGoodPrev && !pinLevel[`PIN_VBAT_PRESENT] |=> s_q.missingFlag)
    else $error("missing battery not flagged at power-up");

  reset_block_a: assert property (@(posedge clk) disable iff (reset)
    ctrlWrite && busReq.wdata[`CTRL_RESET_BIT] && busReq.wdata[`CTRL_OSCEN_BIT] |=> s_q.oscEnable)
    else $error("domain reset took effect beside an oscillator enable");

  // supply, isolation and reset of the main side
  stay_main_a: assert property (@(posedge clk) disable iff (reset)
    (s_q.supply == battery_backup_pkg::SUPPLY_MAIN) && !pinLevel[`PIN_MONITOR_ON] |=> !powerCtl.onBattery)
    else $error("domain switched with the main monitor off");

  battery_hold_a: assert property (@(posedge clk) disable iff (reset)
    powerCtl.onBattery && !mainGood |=> powerCtl.onBattery)
    else $error("domain left battery before main power was good");

  detector_main_a: assert property (@(posedge clk) disable iff (reset)
    !powerCtl.detectorEnable |=> !$rose(s_q.brownoutFlag))
    else $error("battery brown-out flagged while on main power");

  isolate_write_a: assert property (@(posedge clk) disable iff (reset)
    powerCtl.inputIsolate |-> !hostWrite)
    else $error("write accepted while inputs are isolated");

  main_reset_a: assert property (@(posedge clk) disable iff (reset)
    !mainGood |=> powerCtl.mainDomainReset)
    else $error("main-only logic not held in reset on main loss");

  access_drop_a: assert property (@(posedge clk) disable iff (reset)
    !mainGood |=> !s_q.accessEnable)
    else $error("access enable survived main power loss");

  // enables only ever rise through a control write; a stray rise would start the crystal unasked
  osc_enable_a: assert property (@(posedge clk) disable iff (reset)
    $rose(crystalEnable) |-> $past(ctrlWrite) && $past(busReq.wdata[`CTRL_OSCEN_BIT]))
    else $error("crystal enabled without a control write");

  monitor_enable_a: assert property (@(posedge clk) disable iff (reset)
    $rose(failMonitorEnable) |-> $past(ctrlWrite) && $past(busReq.wdata[`CTRL_FAILDET_BIT]))
    else $error("failure monitor enabled without a control write");

  ready_gate_a: assert property (@(posedge clk) disable iff (reset)
    !s_q.oscEnable |=> !$rose(s_q.readyFlag))
    else $error("ready flag set with the crystal off");

  raw_clock_gate_a: assert property (@(posedge clk) disable iff (reset)
    crystalRawClock |-> crystalEnable)
    else $error("raw crystal clock seen while disabled");

  select_write_a: assert property (@(posedge clk) disable iff (reset)
    ctrlWrite && !domainReset |=> s_q.clockSelect == $past(busReq.wdata[`CTRL_CLKSEL_BIT]))
    else $error("counter clock select did not follow the write");

  tick_source_a: assert property (@(posedge clk) disable iff (reset)
    counterTick |-> $past(khzTick) || $past(hzTick))
    else $error("counter tick without a crystal output tick");

  // flags and domain reset as software sees them
  missing_clear_a: assert property (@(posedge clk) disable iff (reset)
    hostWrite && hit(busReq, `BBK_STATUS_ADDR) && busReq.wdata[`STAT_MISSING_BIT] && s_q.mainGoodPrev
    |=> !s_q.missingFlag)
    else $error("missing flag not cleared by writing one");

  flags_open_a: assert property (@(posedge clk) disable iff (reset)
    busReq.rd && hit(busReq, `BBK_STATUS_ADDR)
    |=> readData[7] == $past(s_q.missingFlag) && readData[1:0] == $past({s_q.brownoutFlag, s_q.powerOnFlag}))
    else $error("battery flags not readable");

  domain_reset_a: assert property (@(posedge clk) disable iff (reset)
    domainReset |=> !s_q.oscEnable && !s_q.failMonEnable && (s_q.backup0 == `BACKUP_RESET_VALUE))
    else $error("domain reset did not return the defaults");

endmodule

// >>> design/battery_backup_map.svh
// register offsets, field positions, reset values and counts of the backup power domain
`ifndef BATTERY_BACKUP_MAP_SVH
`define BATTERY_BACKUP_MAP_SVH

// register offsets on the plain register port
`define BBK_CTRL_ADDR      3'h0
`define BBK_STATUS_ADDR    3'h1
`define BBK_BACKUP0_ADDR   3'h2
`define BBK_BACKUP1_ADDR   3'h3

// backup_domain_control fields
`define CTRL_RESET_BIT     0
`define CTRL_ACCESS_BIT    1
`define CTRL_FAILDET_BIT   2
`define CTRL_OSCEN_BIT     3
`define CTRL_CLKSEL_BIT    4

// status fields
`define STAT_POWERON_BIT   0
`define STAT_BROWNOUT_BIT  1
`define STAT_FAIL_BIT      2
`define STAT_READY_BIT     3
`define STAT_MISSING_BIT   7

// reset values
`define CTRL_RESET_VALUE   8'h00
`define BACKUP_RESET_VALUE 8'h00

// crystal edges per output tick: 32768 / 32 = 1024, 32768 / 32768 = 1
`define KHZ_DIVIDE         32
`define HZ_DIVIDE          32768

// positions of the pin inputs in the synchroniser vector
`define PIN_MAIN_POR       0
`define PIN_MAIN_BROWNOUT  1
`define PIN_MONITOR_ON     2
`define PIN_VBAT_PRESENT   3
`define PIN_VBAT_LOW       4
`define PIN_CRYSTAL        5
`define PIN_CRYSTAL_STABLE 6
`define PIN_CRYSTAL_FAULT  7
`define PIN_ULP_TICK       8
`define PIN_COUNT          9

`endif

// >>> design/battery_backup_pkg.sv
// types shared by the backup power domain control logic
package battery_backup_pkg;

  typedef enum logic {SUPPLY_MAIN, SUPPLY_BATTERY} supply_t;

  // one register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;

  // supply switch outputs toward the analog power path
  typedef struct packed {
    logic onBattery;
    logic detectorEnable;
    logic inputIsolate;
    logic mainDomainReset;
  } power_ctl_t;

  // whole state of the control logic
  typedef struct packed {
    supply_t     supply;
    logic        mainGoodPrev;
    logic        accessEnable;
    logic        oscEnable;
    logic        failMonEnable;
    logic        clockSelect;
    logic        missingFlag;
    logic        powerOnFlag;
    logic        brownoutFlag;
    logic        readyFlag;
    logic        failFlag;
    logic [7:0]  backup0;
    logic [7:0]  backup1;
    logic [4:0]  khzCount;
    logic [14:0] hzCount;
    logic        counterTick;
    logic [7:0]  readData;
  } domain_state_t;

endpackage

// >>> design/pin_sync.sv
// two-flop synchronisers with rising-edge detect for the domain's pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
    logic [WIDTH-1:0] last;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  // the first stage feeds only the second; edges are taken from later stages
  always_comb begin
    s_d        = s_q;
    s_d.first  = pinIn;
    s_d.second = s_q.first;
    s_d.last   = s_q.second;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level = s_q.second;
  assign rise  = s_q.second & ~s_q.last;

endmodule

// >>> test/vbat_crystal_model.sv
// battery pin and external crystal model for the backup domain bench
`timescale 1ns/1ps
module vbat_crystal_model (
  input  wire logic crystalEnable,
  input  wire logic batOn,
  input  wire logic batLow,
  input  wire logic fault,
  output logic      vbatPresent,
  output logic      vbatLow,
  output logic      crystalIn,
  output logic      crystalStable,
  output logic      crystalFault
);
  int edges;
  // comparator can only report low while a battery is fitted
  assign vbatPresent = batOn;
  assign vbatLow = batOn & batLow;
  assign crystalFault = fault;
  // crystal stands still while disabled; odd half period keeps it unrelated to clk
  initial begin
    crystalIn = 1'b0;
    crystalStable = 1'b0;
    edges = 0;
    forever begin
      if (crystalEnable) begin
        #101 crystalIn = ~crystalIn;
        edges++;
        crystalStable = (edges > 6);
      end else begin
        crystalIn = 1'b0;
        crystalStable = 1'b0;
        edges = 0;
        @(crystalEnable);
      end
    end
  end
endmodule

// >>> test/tb_top.sv
// self-checking bench of the battery-backed power domain control logic
`timescale 1ns/1ps
`include "battery_backup_map.svh"
module tb_top;
  localparam int KD = 4;
  localparam int HD = 8;
  logic                           clk, reset, mainPowerOnReset, mainBrownout, mainMonitorEnabled, ulpTick;
  logic                           vbatPresent, vbatLow, crystalIn, crystalStable, crystalFault;
  logic                           crystalEnable, failMonitorEnable, crystalRawClock, counterTick;
  logic                           batOn, batLow, fault;
  logic [7:0]                     readData, d, r0, r1;
  battery_backup_pkg::bus_req_t   busReq;
  battery_backup_pkg::power_ctl_t powerCtl;
  int                             num_errors, n_checks, cyc, c;

  battery_backup_power_domain #(.KHZ_DIVIDE(KD), .HZ_DIVIDE(HD)) uut (
    .clk(clk), .reset(reset), .busReq(busReq), .readData(readData),
    .mainPowerOnReset(mainPowerOnReset), .mainBrownout(mainBrownout),
    .mainMonitorEnabled(mainMonitorEnabled), .vbatPresent(vbatPresent), .vbatLow(vbatLow),
    .crystalIn(crystalIn), .crystalStable(crystalStable), .crystalFault(crystalFault),
    .ulpTick(ulpTick), .powerCtl(powerCtl), .crystalEnable(crystalEnable),
    .failMonitorEnable(failMonitorEnable), .crystalRawClock(crystalRawClock), .counterTick(counterTick));

  vbat_crystal_model partner (
    .crystalEnable(crystalEnable), .batOn(batOn), .batLow(batLow), .fault(fault),
    .vbatPresent(vbatPresent), .vbatLow(vbatLow), .crystalIn(crystalIn),
    .crystalStable(crystalStable), .crystalFault(crystalFault));

  // expected control readback with access enable set
  function automatic logic [7:0] ctrlExp(logic sel, logic osc, logic fm);
    return {3'h0, sel, osc, fm, 1'b1, 1'b0};
  endfunction
  // clk cycles per selected output period, crystal period 202 ns
  function automatic int spanExp(int div);
    return div * 202 / 25;
  endfunction

  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic wrR(logic [2:0] a, logic [7:0] v);
    @(posedge clk);
    busReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    busReq.wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rdR(logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    busReq.rd <= 1'b0;
    #1 v = readData;
  endtask
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkR(int got, int exp);
    n_checks++;
    if (got < exp - 2 || got > exp + 2) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // cycles between two counter ticks, the first tick only synchronises
  task automatic span(output int n);
    int t;
    t = 0;
    n = 1;
    while (counterTick !== 1'b1 && t < 2000) begin
      tick();
      t++;
    end
    tick();
    while (counterTick !== 1'b1 && t < 4000) begin
      tick();
      t++;
      n++;
    end
  endtask
  task automatic ulpPulse;
    ulpTick <= 1'b1;
    repeat (4) @(posedge clk);
    ulpTick <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic complete_run;
    if (num_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // hang guard, the whole run needs under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      complete_run();
    end
  end

  initial begin
    reset = 1'b1;
    busReq = '0;
    mainPowerOnReset = 1'b0;
    mainBrownout = 1'b0;
    mainMonitorEnabled = 1'b1;
    ulpTick = 1'b0;
    batOn = 1'b0;
    batLow = 1'b0;
    fault = 1'b0;
    void'($urandom(32'h1d2c));
    r0 = 8'($urandom);
    r1 = 8'($urandom);
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    repeat (6) @(posedge clk);
    // battery flags work without access enable
    rdR(`BBK_STATUS_ADDR, d); chk(d, 8'h80);
    wrR(`BBK_STATUS_ADDR, 8'h80); rdR(`BBK_STATUS_ADDR, d); chk(d, 8'h00);
    batOn <= 1'b1;
    repeat (6) @(posedge clk);
    rdR(`BBK_STATUS_ADDR, d); chk(d, 8'h01);
    wrR(`BBK_STATUS_ADDR, 8'h01);
    wrR(`BBK_BACKUP0_ADDR, r0); rdR(`BBK_BACKUP0_ADDR, d); chk(d, 8'h00);
    wrR(`BBK_CTRL_ADDR, 8'h02); rdR(`BBK_CTRL_ADDR, d); chk(d, ctrlExp(0, 0, 0));
    wrR(`BBK_BACKUP0_ADDR, r0); wrR(`BBK_BACKUP1_ADDR, r1);
    rdR(`BBK_BACKUP0_ADDR, d); chk(d, r0);
    rdR(`BBK_BACKUP1_ADDR, d); chk(d, r1);
    for (int a = 4; a < 8; a++) begin
      rdR(3'(a), d); chk(d, 8'h00);
    end
    // nothing may tick before the crystal runs
    c = 0;
    repeat (300) begin
      tick();
      c += int'(counterTick === 1'b1);
    end
    chk(8'(c), 8'h00);
    chk({6'h0, crystalEnable, crystalRawClock}, 8'h00);
    // enable plus domain reset in one write: the reset must not land
    wrR(`BBK_CTRL_ADDR, 8'h0b); rdR(`BBK_CTRL_ADDR, d); chk(d, ctrlExp(0, 1, 0));
    rdR(`BBK_BACKUP0_ADDR, d); chk(d, r0);
    repeat (40) @(posedge clk);
    rdR(`BBK_STATUS_ADDR, d); chk(d, 8'h08);
    // raw clock high about half of 20 cycles once the crystal runs
    c = 0;
    repeat (20) begin
      tick();
      c += int'(crystalRawClock === 1'b1);
    end
    chkR(c, 10);
    chk({7'h0, crystalEnable}, 8'h01);
    span(c); chkR(c, spanExp(HD));
    wrR(`BBK_CTRL_ADDR, 8'h1a);
    span(c); chkR(c, spanExp(KD));
    fault <= 1'b1;
    repeat (10) @(posedge clk);
    rdR(`BBK_STATUS_ADDR, d); chk(d, 8'h08);
    wrR(`BBK_CTRL_ADDR, 8'h16); rdR(`BBK_STATUS_ADDR, d); chk(d, 8'h0c);
    chk({7'h0, failMonitorEnable}, 8'h01);
    wrR(`BBK_CTRL_ADDR, 8'h03); rdR(`BBK_CTRL_ADDR, d); chk(d, ctrlExp(0, 0, 0));
    rdR(`BBK_STATUS_ADDR, d); chk(d, 8'h00);
    rdR(`BBK_BACKUP0_ADDR, d); chk(d, 8'h00);
    fault <= 1'b0;
    // monitor off: a brownout must not switch the supply
    mainMonitorEnabled <= 1'b0;
    mainBrownout <= 1'b1;
    repeat (10) @(posedge clk);
    // main not good, so only the main-side reset shows
    chk({4'h0, powerCtl}, 8'h01);
    mainBrownout <= 1'b0;
    mainMonitorEnabled <= 1'b1;
    batLow <= 1'b1;
    repeat (6) @(posedge clk);
    ulpPulse();
    rdR(`BBK_STATUS_ADDR, d); chk(d, 8'h00);
    wrR(`BBK_CTRL_ADDR, 8'h02); wrR(`BBK_BACKUP0_ADDR, r1);
    // second pass samples the battery, the first must not
    for (int k = 0; k < 2; k++) begin
      mainBrownout <= 1'b1;
      repeat (8) @(posedge clk);
      chk({4'h0, powerCtl}, 8'h0f);
      wrR(`BBK_BACKUP0_ADDR, ~r1);
      if (k == 1) begin
        ulpPulse();
      end
      mainPowerOnReset <= 1'b1;
      mainBrownout <= 1'b0;
      repeat (10) @(posedge clk);
      chk({7'h0, powerCtl.onBattery}, 8'h01);
      mainPowerOnReset <= 1'b0;
      repeat (10) @(posedge clk);
      chk({4'h0, powerCtl}, 8'h00);
      rdR(`BBK_STATUS_ADDR, d); chk(d, {6'h0, k[0], 1'b0});
      rdR(`BBK_CTRL_ADDR, d); chk(d, 8'h00);
      wrR(`BBK_CTRL_ADDR, 8'h02); rdR(`BBK_BACKUP0_ADDR, d); chk(d, r1);
    end
    complete_run();
  end
endmodule
